// ==== core/tcc_pkg.sv ====
// Package with register map, field layout and mode encodings for the 8-bit timer/counter compare unit.
package tcc_pkg;

   // ==========================================================
   // Register offsets (byte addresses, one word each)
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_COUNT   = 8'h04;
   localparam logic [7:0] ADDR_COMPARE = 8'h08;
   localparam logic [7:0] ADDR_FLAGS   = 8'h0c;
   localparam logic [7:0] ADDR_MASK    = 8'h10;
   localparam logic [7:0] ADDR_ASYNC   = 8'h14;
   localparam logic [7:0] ADDR_PORT    = 8'h18;

   // ==========================================================
   // Control register field positions
   localparam int CTRL_CS_LSB  = 0;
   localparam int CTRL_WGM_LSB = 3;
   localparam int CTRL_COM_LSB = 5;
   localparam int CTRL_FOC_BIT = 7;

   // Flag and mask bit positions
   localparam int FLAG_OVF_BIT = 0;
   localparam int FLAG_CMP_BIT = 1;

   // Port register bit positions
   localparam int PORT_VAL_BIT = 0;
   localparam int PORT_DIR_BIT = 1;

   // ==========================================================
   // Reset values and counter extremes
   localparam logic [7:0] RST_BYTE    = 8'h00;
   localparam logic [7:0] COUNT_MAX   = 8'hff;
   localparam logic [7:0] COUNT_BOT   = 8'h00;
   localparam logic [2:0] CS_STOPPED  = 3'h0;

   // Prescaler width, set by the widest tap of clock select 2..7.
   localparam int PRE_W = 10;

   // ==========================================================
   typedef enum logic [1:0]
   {
      TCC_WGM_NORMAL = 2'b00,
      TCC_WGM_PHASE  = 2'b01,
      TCC_WGM_CTC    = 2'b10,
      TCC_WGM_FAST   = 2'b11
   } tcc_wgm_t;

   typedef enum logic [1:0]
   {
      TCC_COM_OFF    = 2'b00,
      TCC_COM_TOGGLE = 2'b01,
      TCC_COM_CLEAR  = 2'b10,
      TCC_COM_SET    = 2'b11
   } tcc_com_t;

   // Wishbone request from the bus master.
   typedef struct packed
   {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [7:0]  adr;
      logic [31:0] dat;
   } tcc_wb_req_t;

   // Wishbone answer to the bus master.
   typedef struct packed
   {
      logic        ack;
      logic [31:0] dat;
   } tcc_wb_rsp_t;

endpackage

// ==== core/tcc_timer.sv ====
// 8-bit timer/counter with one output compare channel behind a classic Wishbone slave.
`timescale 1ns/1ps
// What this block does
// - Timer ticks come from the core clock unless async select picks the crystal.
// - Each tick clears, increments or decrements the counter by one per mode.
// - Clock select zero produces no tick and the counter stays stopped.
// - Software reads and writes the counter whether or not ticks arrive.
// - A software counter write beats any same-cycle clear or count.
// - Waveform mode picks the count sequence; output mode never affects counting.
// - Counter equal compare value sets the compare flag at the next tick.
// - Enabled compare flag raises an interrupt; service or writing one clears it.
// - PWM modes double buffer compare value, loaded at top or bottom.
// - Compare writes go to buffer when buffering, else to the live register.
// - Non-PWM force strobe acts on output like a match, no flag, no clear.
// - A counter write blocks the compare flag and output action at the next tick, not the clear-on-match.
// - Output state is kept across waveform mode changes.
// - Output mode is unbuffered and governs the first match after the write.
// - Nonzero output mode puts compare output on the pin; direction stays separate.
// - Output mode zero leaves the output state unchanged on match.
// - Normal mode counts up and wraps from ff to 00.
// - Normal mode sets overflow flag when counter becomes zero; counting never clears it.
// - Overflow flag can raise an interrupt and is cleared on service.
// - Clear-on-match mode resets counter to zero when it equals compare value.
// - Fast PWM counts 0..255; mode 2 clears on match sets at bottom, 3 inverts.
// - Phase correct counts up, down; overflow at zero; output changes both directions.
// - Non-PWM output mode one toggles output state at each match.

module tcc_timer
(
   // Clock and reset
   input  wire logic                 core_clk_i,
   input  wire logic                 nrst_i,
   // Wishbone slave
   input  wire tcc_pkg::tcc_wb_req_t wb_req_i,
   output tcc_pkg::tcc_wb_rsp_t      wb_rsp_o,
   // Crystal oscillator and interrupt service
   input  wire logic                 crystal_pin_in_i,
   input  wire logic                 ovf_irq_ack_i,
   input  wire logic                 cmp_irq_ack_i,
   // Interrupt requests
   output logic                      ovf_irq_o,
   output logic                      cmp_irq_o,
   // Output compare pin
   output logic                      compare_output_o,
   output logic                      compare_output_oe_n_o
);
   import tcc_pkg::*;

   // ==========================================================
   // Registers
   logic [2:0]      clock_select_field;
   tcc_wgm_t        waveform_mode_field;
   tcc_com_t        output_mode_field;
   logic [7:0]      count_value;
   logic [7:0]      compare_value;
   logic [7:0]      compare_buffer;
   logic            overflow_flag;
   logic            compare_match_flag;
   logic            compare_irq_enable;
   logic            overflow_irq_enable;
   logic            async_clock_select;
   logic            port_value;
   logic            output_pin_direction_bit;
   logic            oc_state;
   logic            count_down;
   logic            block_match;
   logic            ack;
   logic [31:0]     rdata;
   logic [PRE_W-1:0] prescale;
   logic [1:0]      xtal_sync;
   logic            xtal_prev;

   // ==========================================================
   // Bus decode
   wire   bus_req    = wb_req_i.cyc & wb_req_i.stb & ~ack;
   wire   bus_wr     = bus_req & wb_req_i.we & wb_req_i.sel[0];
   wire   wr_ctrl    = bus_wr & (wb_req_i.adr == ADDR_CTRL);
   wire   wr_count   = bus_wr & (wb_req_i.adr == ADDR_COUNT);
   wire   wr_compare = bus_wr & (wb_req_i.adr == ADDR_COMPARE);
   wire   wr_flags   = bus_wr & (wb_req_i.adr == ADDR_FLAGS);
   wire   wr_mask    = bus_wr & (wb_req_i.adr == ADDR_MASK);
   wire   wr_async   = bus_wr & (wb_req_i.adr == ADDR_ASYNC);
   wire   wr_port    = bus_wr & (wb_req_i.adr == ADDR_PORT);
   wire [7:0] wdat   = wb_req_i.dat[7:0];

   // ==========================================================
   // Tick generation
   // The crystal is sampled in the core domain, so it must run below half the core rate.
   wire   xtal_rise  = xtal_sync[1] & ~xtal_prev;
   wire   base_tick  = async_clock_select ? xtal_rise : 1'b1;
   wire [PRE_W-1:0] next_prescale = base_tick ? prescale + 1'b1 : prescale;

   function automatic logic tap_hit(input logic [PRE_W-1:0] p, input int bits);
      tap_hit = (p & ((PRE_W)'((1 << bits) - 1))) == '0;
   endfunction

   logic timer_tick;
   always_comb
   begin
      case (clock_select_field)
         3'h0:    timer_tick = 1'b0;
         3'h1:    timer_tick = base_tick;
         3'h2:    timer_tick = base_tick & tap_hit(next_prescale, 3);
         3'h3:    timer_tick = base_tick & tap_hit(next_prescale, 5);
         3'h4:    timer_tick = base_tick & tap_hit(next_prescale, 6);
         3'h5:    timer_tick = base_tick & tap_hit(next_prescale, 7);
         3'h6:    timer_tick = base_tick & tap_hit(next_prescale, 8);
         3'h7:    timer_tick = base_tick & tap_hit(next_prescale, 10);
         default: timer_tick = 1'b0;
      endcase
   end

   // ==========================================================
   // Counter sequencing
   wire   is_pwm     = (waveform_mode_field == TCC_WGM_PHASE) | (waveform_mode_field == TCC_WGM_FAST);
   wire   at_max     = (count_value == COUNT_MAX);
   wire   at_bot     = (count_value == COUNT_BOT);
   wire   raw_match  = (count_value == compare_value);
   wire   match_ev   = timer_tick & raw_match & ~block_match;
   wire   ctc_clear  = (waveform_mode_field == TCC_WGM_CTC) & raw_match;
   wire   phase_down = count_down ? ~at_bot : at_max;
   wire   next_dir   = (waveform_mode_field == TCC_WGM_PHASE) ? phase_down : 1'b0;

   logic [7:0] next_count;
   always_comb
   begin
      case (waveform_mode_field)
         TCC_WGM_NORMAL: next_count = count_value + 8'h01;
         TCC_WGM_PHASE:  next_count = next_dir ? count_value - 8'h01 : count_value + 8'h01;
         TCC_WGM_CTC:    next_count = ctc_clear ? COUNT_BOT : count_value + 8'h01;
         TCC_WGM_FAST:   next_count = at_max ? COUNT_BOT : count_value + 8'h01;
         default:        next_count = count_value + 8'h01;
      endcase
   end

   // A clear on match is no overflow; only leaving the top or reaching bottom on the way down is.
   wire   ovf_ev     = timer_tick & (next_count == COUNT_BOT) & ~wr_count
                       & (at_max | (waveform_mode_field == TCC_WGM_PHASE));
   // Buffer loads at bottom in fast mode and at top in phase mode.
   wire   buf_load   = timer_tick & ~wr_count
                       & ((waveform_mode_field == TCC_WGM_FAST) ? at_max : at_max & ~count_down);

   // ==========================================================
   // Waveform output
   wire   force_ev   = wr_ctrl & wdat[CTRL_FOC_BIT] & ~is_pwm;
   tcc_com_t act_com;
   assign act_com = force_ev ? tcc_com_t'(wdat[CTRL_COM_LSB +: 2]) : output_mode_field;

   logic next_oc;
   always_comb
   begin
      next_oc = oc_state;
      if ((match_ev | force_ev) & ~is_pwm)
      begin
         case (act_com)
            TCC_COM_TOGGLE: next_oc = ~oc_state;
            TCC_COM_CLEAR:  next_oc = 1'b0;
            TCC_COM_SET:    next_oc = 1'b1;
            default:        next_oc = oc_state;
         endcase
      end
      else if (is_pwm & timer_tick & ~wr_count)
      begin
         if (match_ev & (act_com == TCC_COM_TOGGLE) & (waveform_mode_field == TCC_WGM_FAST))
            next_oc = ~oc_state;
         else if (match_ev & act_com[1])
            next_oc = act_com[0] ^ ((waveform_mode_field == TCC_WGM_PHASE) & count_down);
         else if ((waveform_mode_field == TCC_WGM_FAST) & at_max & act_com[1])
            next_oc = ~act_com[0];
      end
   end

   // ==========================================================
   // Read mux
   logic [7:0] rd_byte;
   always_comb
   begin
      case (wb_req_i.adr)
         ADDR_CTRL:    rd_byte = {1'b0, output_mode_field, waveform_mode_field, clock_select_field};
         ADDR_COUNT:   rd_byte = count_value;
         ADDR_COMPARE: rd_byte = is_pwm ? compare_buffer : compare_value;
         ADDR_FLAGS:   rd_byte = {6'h00, compare_match_flag, overflow_flag};
         ADDR_MASK:    rd_byte = {6'h00, compare_irq_enable, overflow_irq_enable};
         ADDR_ASYNC:   rd_byte = {7'h00, async_clock_select};
         ADDR_PORT:    rd_byte = {6'h00, output_pin_direction_bit, port_value};
         default:      rd_byte = RST_BYTE;
      endcase
   end

   // ==========================================================
   // State registers
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         xtal_sync <= 2'b00;
         xtal_prev <= 1'b0;
         prescale  <= '0;
         ack       <= 1'b0;
         rdata     <= '0;
      end
      else
      begin
         xtal_sync <= {xtal_sync[0], crystal_pin_in_i};
         xtal_prev <= xtal_sync[1];
         prescale  <= (clock_select_field == CS_STOPPED) ? '0 : next_prescale;
         ack       <= bus_req;
         rdata     <= {24'h000000, rd_byte};
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         count_value <= RST_BYTE;
         count_down  <= 1'b0;
         block_match <= 1'b0;
      end
      else
      begin
         if (wr_count)
            count_value <= wdat;
         else if (timer_tick)
            count_value <= next_count;
         if (timer_tick & ~wr_count)
            count_down <= next_dir;
         if (wr_count)
            block_match <= 1'b1;
         else if (timer_tick)
            block_match <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         compare_value  <= RST_BYTE;
         compare_buffer <= RST_BYTE;
      end
      else
      begin
         if (wr_compare)
            compare_buffer <= wdat;
         if (wr_compare & ~is_pwm)
            compare_value <= wdat;
         else if (buf_load)
            compare_value <= compare_buffer;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         clock_select_field       <= CS_STOPPED;
         waveform_mode_field      <= TCC_WGM_NORMAL;
         output_mode_field        <= TCC_COM_OFF;
         compare_irq_enable       <= 1'b0;
         overflow_irq_enable      <= 1'b0;
         async_clock_select       <= 1'b0;
         port_value               <= 1'b0;
         output_pin_direction_bit <= 1'b0;
         oc_state                 <= 1'b0;
      end
      else
      begin
         if (wr_ctrl)
         begin
            clock_select_field  <= wdat[CTRL_CS_LSB +: 3];
            waveform_mode_field <= tcc_wgm_t'(wdat[CTRL_WGM_LSB +: 2]);
            output_mode_field   <= tcc_com_t'(wdat[CTRL_COM_LSB +: 2]);
         end
         if (wr_mask)
         begin
            overflow_irq_enable <= wdat[FLAG_OVF_BIT];
            compare_irq_enable  <= wdat[FLAG_CMP_BIT];
         end
         if (wr_async)
            async_clock_select <= wdat[0];
         if (wr_port)
         begin
            port_value               <= wdat[PORT_VAL_BIT];
            output_pin_direction_bit <= wdat[PORT_DIR_BIT];
         end
         oc_state <= next_oc;
      end
   end

   // Hardware set wins over a clear in the same cycle.
   always_ff @(posedge core_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         overflow_flag      <= 1'b0;
         compare_match_flag <= 1'b0;
      end
      else
      begin
         if (ovf_ev)
            overflow_flag <= 1'b1;
         else if ((wr_flags & wdat[FLAG_OVF_BIT]) | (ovf_irq_ack_i & ovf_irq_o))
            overflow_flag <= 1'b0;
         if (match_ev)
            compare_match_flag <= 1'b1;
         else if ((wr_flags & wdat[FLAG_CMP_BIT]) | (cmp_irq_ack_i & cmp_irq_o))
            compare_match_flag <= 1'b0;
      end
   end

   // ==========================================================
   // Outputs
   assign wb_rsp_o              = '{ack: ack, dat: rdata};
   assign ovf_irq_o             = overflow_flag & overflow_irq_enable;
   assign cmp_irq_o             = compare_match_flag & compare_irq_enable;
   assign compare_output_o      = (output_mode_field != TCC_COM_OFF) ? oc_state : port_value;
   assign compare_output_oe_n_o = ~output_pin_direction_bit;

   // ==========================================================
   // Checks
   chk_stop_holds: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (clock_select_field == CS_STOPPED) && !wr_count |=> $stable(count_value))
      else $error("counter moved while stopped");
   chk_write_wins: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      wr_count |=> count_value == $past(wdat))
      else $error("counter write lost");
   chk_match_flag: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      timer_tick && raw_match && !block_match |=> compare_match_flag)
      else $error("match did not set flag");
   chk_block_match: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      wr_count && !compare_match_flag ##1 (timer_tick && !wr_flags) |=> !$rose(compare_match_flag))
      else $error("match not blocked after counter write");
   chk_normal_wrap: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      timer_tick && !wr_count && waveform_mode_field == TCC_WGM_NORMAL && at_max |=> count_value == COUNT_BOT)
      else $error("normal mode did not wrap");
   chk_ctc_clear: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      timer_tick && !wr_count && waveform_mode_field == TCC_WGM_CTC && raw_match |=> count_value == COUNT_BOT)
      else $error("clear-on-match mode did not clear");
   chk_fast_bottom: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      timer_tick && !wr_count && waveform_mode_field == TCC_WGM_FAST && at_max |=> count_value == COUNT_BOT)
      else $error("fast mode did not restart at bottom");
   chk_cmp_service: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      cmp_irq_ack_i && cmp_irq_o && !match_ev |=> !compare_match_flag)
      else $error("serviced compare flag not cleared");
   chk_ovf_set: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      ovf_ev |=> overflow_flag)
      else $error("overflow flag not set");
   chk_cmp_irq: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      compare_match_flag && compare_irq_enable |-> cmp_irq_o)
      else $error("compare interrupt missing");
   chk_force_noflag: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      force_ev && !match_ev && !compare_match_flag |=> !compare_match_flag)
      else $error("force set the compare flag");
   chk_pin_select: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      output_mode_field != TCC_COM_OFF |-> compare_output_o == oc_state)
      else $error("pin not driven by compare output");
   chk_com_off: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      output_mode_field == TCC_COM_OFF && !force_ev |=> oc_state == $past(oc_state))
      else $error("output state moved with mode off");
   chk_bus_ack: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      ack |=> !ack)
      else $error("ack held too long");

   cov_ovf:   cover property (@(posedge core_clk_i) disable iff (!nrst_i) ovf_ev);
   cov_match: cover property (@(posedge core_clk_i) disable iff (!nrst_i) match_ev && ctc_clear);
   cov_force: cover property (@(posedge core_clk_i) disable iff (!nrst_i) force_ev);
   cov_load:  cover property (@(posedge core_clk_i) disable iff (!nrst_i) buf_load);
   cov_top:   cover property (@(posedge core_clk_i) disable iff (!nrst_i)
      timer_tick && waveform_mode_field == TCC_WGM_PHASE && at_max);
endmodule

// ==== verification/tb.sv ====
// Self-checking testbench for the 8-bit timer/counter compare unit.
`timescale 1ns/1ps
module tb;
   import tcc_pkg::*;
   // ==========================================================
   // Signals
   logic                 core_clk_i = 1'b0;
   logic                 nrst_i     = 1'b0;
   tcc_wb_req_t          req        = '0;
   tcc_wb_rsp_t          rsp;
   logic                 xtal       = 1'b0;
   logic                 ovf_ack    = 1'b0;
   logic                 cmp_ack    = 1'b0;
   logic                 ovf_irq;
   logic                 cmp_irq;
   logic                 cout;
   logic                 oe_n;
   int                   num_errors      = 0;
   int                   samples_checked = 0;

   always #20 core_clk_i = ~core_clk_i;

   tcc_timer dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .wb_req_i(req), .wb_rsp_o(rsp),
      .crystal_pin_in_i(xtal), .ovf_irq_ack_i(ovf_ack), .cmp_irq_ack_i(cmp_ack), .ovf_irq_o(ovf_irq),
      .cmp_irq_o(cmp_irq), .compare_output_o(cout), .compare_output_oe_n_o(oe_n));

   // ==========================================================
   // Reporting
   task automatic print_verdict();
      if (num_errors == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // ==========================================================
   // Bus access; the master waits for ack, never for a fixed count.
   task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge core_clk_i);
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h1, adr: a, dat: {24'h0, d}};
      do
      begin
         @(posedge core_clk_i);
         n++;
      end while (rsp.ack !== 1'b1 && n < 20);
      q = rsp.dat[7:0];
      req <= '0;
      if (n >= 20)
      begin
         num_errors++;
         print_verdict();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      wb(1'b0, a, 8'h00, q);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      rd(a, q);
      chk_byte(q, exp);
   endtask

   // Polls the flag register a bounded number of times.
   task automatic wait_flag(input int b, input int lim);
      logic [7:0] q;
      int         n;
      n = 0;
      q = 8'h00;
      while (q[b] !== 1'b1 && n < lim)
      begin
         rd(ADDR_FLAGS, q);
         n++;
      end
      chk_bit(q[b], 1'b1);
   endtask

   function automatic logic [7:0] ctl(input logic [2:0] cs, input logic [1:0] wgm, input logic [1:0] com,
                                      input logic foc);
      return {foc, com, wgm, cs};
   endfunction

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      for (int a = 0; a < 8; a++)
         rdc(8'(a * 4), 8'h00);
      wr(8'h1c, 8'hff);
      rdc(8'h1c, 8'h00);
      chk_bit(oe_n, 1'b1);
      chk_bit(cout, 1'b0);
   endtask

   task automatic t_count();
      logic [7:0] q;
      wr(ADDR_COUNT, 8'h5a);
      repeat (10) @(posedge core_clk_i);
      rdc(ADDR_COUNT, 8'h5a);
      wr(ADDR_CTRL, ctl(3'h1, 2'h0, 2'h0, 1'b0));
      wr(ADDR_COUNT, 8'h40);
      wr(ADDR_CTRL, 8'h00);
      rd(ADDR_COUNT, q);
      chk_bit(q >= 8'h40 && q <= 8'h48, 1'b1);
   endtask

   task automatic t_overflow();
      logic [7:0] q;
      wr(ADDR_FLAGS, 8'h03);
      wr(ADDR_MASK, 8'h01);
      wr(ADDR_COUNT, 8'hfe);
      chk_bit(ovf_irq, 1'b0);
      wr(ADDR_CTRL, ctl(3'h1, 2'h0, 2'h2, 1'b0));
      wait_flag(FLAG_OVF_BIT, 10);
      wr(ADDR_CTRL, 8'h00);
      rd(ADDR_COUNT, q);
      chk_bit(q < 8'h40, 1'b1);
      chk_bit(ovf_irq, 1'b1);
      ovf_ack <= 1'b1;
      @(posedge core_clk_i);
      ovf_ack <= 1'b0;
      @(posedge core_clk_i);
      @(posedge core_clk_i);
      chk_bit(ovf_irq, 1'b0);
      wr(ADDR_MASK, 8'h02);
   endtask

   task automatic t_compare();
      wr(ADDR_FLAGS, 8'h03);
      wr(ADDR_COMPARE, 8'h10);
      wr(ADDR_COUNT, 8'h10);
      wr(ADDR_CTRL, ctl(3'h1, 2'h0, 2'h0, 1'b0));
      repeat (8) @(posedge core_clk_i);
      wr(ADDR_CTRL, 8'h00);
      rdc(ADDR_FLAGS, 8'h00);
      chk_bit(cmp_irq, 1'b0);
      wr(ADDR_COUNT, 8'h0e);
      wr(ADDR_CTRL, ctl(3'h1, 2'h0, 2'h0, 1'b0));
      wait_flag(FLAG_CMP_BIT, 10);
      wr(ADDR_CTRL, 8'h00);
      chk_bit(cmp_irq, 1'b1);
      cmp_ack <= 1'b1;
      @(posedge core_clk_i);
      cmp_ack <= 1'b0;
      @(posedge core_clk_i);
      @(posedge core_clk_i);
      chk_bit(cmp_irq, 1'b0);
      wr(ADDR_COUNT, 8'h0e);
      wr(ADDR_CTRL, ctl(3'h1, 2'h0, 2'h0, 1'b0));
      wait_flag(FLAG_CMP_BIT, 10);
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_FLAGS, 8'h02);
      rdc(ADDR_FLAGS, 8'h00);
      wr(ADDR_MASK, 8'h00);
   endtask

   task automatic t_modes();
      logic [7:0] q;
      wr(ADDR_COMPARE, 8'h05);
      wr(ADDR_COUNT, 8'h00);
      wr(ADDR_CTRL, ctl(3'h1, 2'h2, 2'h0, 1'b0));
      repeat (12)
      begin
         rd(ADDR_COUNT, q);
         chk_bit(q <= 8'h05, 1'b1);
      end
      rd(ADDR_FLAGS, q);
      chk_bit(q[FLAG_OVF_BIT], 1'b0);
      wr(ADDR_COUNT, 8'hfc);
      wr(ADDR_CTRL, ctl(3'h1, 2'h1, 2'h0, 1'b0));
      repeat (12) @(posedge core_clk_i);
      wr(ADDR_CTRL, 8'h00);
      rd(ADDR_COUNT, q);
      chk_bit(q >= 8'he0 && q != 8'hff, 1'b1);
   endtask

   task automatic t_output();
      logic [7:0] c0;
      logic [1:0] com[4] = '{2'h2, 2'h3, 2'h1, 2'h1};
      logic       exp[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
      wr(ADDR_FLAGS, 8'h03);
      wr(ADDR_PORT, 8'h02);
      chk_bit(oe_n, 1'b0);
      rd(ADDR_COUNT, c0);
      for (int i = 0; i < 4; i++)
      begin
         wr(ADDR_CTRL, ctl(3'h0, 2'h0, com[i], 1'b1));
         chk_bit(cout, exp[i]);
      end
      rdc(ADDR_FLAGS, 8'h00);
      rdc(ADDR_COUNT, c0);
      wr(ADDR_CTRL, 8'h00);
      chk_bit(cout, 1'b0);
      wr(ADDR_COMPARE, 8'h20);
      wr(ADDR_COUNT, 8'h1e);
      wr(ADDR_CTRL, ctl(3'h1, 2'h0, 2'h0, 1'b0));
      wait_flag(FLAG_CMP_BIT, 10);
      wr(ADDR_CTRL, ctl(3'h0, 2'h0, 2'h1, 1'b0));
      chk_bit(cout, 1'b1);
      wr(ADDR_CTRL, ctl(3'h0, 2'h3, 2'h1, 1'b0));
      chk_bit(cout, 1'b1);
      wr(ADDR_CTRL, ctl(3'h0, 2'h3, 2'h2, 1'b1));
      chk_bit(cout, 1'b1);
      rdc(ADDR_CTRL, ctl(3'h0, 2'h3, 2'h2, 1'b0));
   endtask

   // A short poll bound tells the buffered value apart from the live one.
   task automatic t_buffer();
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_FLAGS, 8'h03);
      wr(ADDR_COMPARE, 8'h40);
      wr(ADDR_CTRL, ctl(3'h0, 2'h3, 2'h0, 1'b0));
      wr(ADDR_COMPARE, 8'h80);
      rdc(ADDR_COMPARE, 8'h80);
      wr(ADDR_COUNT, 8'h3d);
      wr(ADDR_CTRL, ctl(3'h1, 2'h3, 2'h0, 1'b0));
      wait_flag(FLAG_CMP_BIT, 8);
      wr(ADDR_CTRL, 8'h00);
   endtask

   task automatic t_crystal();
      wr(ADDR_ASYNC, 8'h01);
      wr(ADDR_COUNT, 8'h00);
      wr(ADDR_CTRL, ctl(3'h1, 2'h0, 2'h0, 1'b0));
      repeat (10) @(posedge core_clk_i);
      rdc(ADDR_COUNT, 8'h00);
      repeat (10)
      begin
         repeat (4) @(posedge core_clk_i);
         xtal <= 1'b1;
         repeat (4) @(posedge core_clk_i);
         xtal <= 1'b0;
      end
      repeat (8) @(posedge core_clk_i);
      wr(ADDR_CTRL, 8'h00);
      rdc(ADDR_COUNT, 8'h0a);
      wr(ADDR_ASYNC, 8'h00);
   endtask

   // Divide by eight: ticks fall on every eighth edge after the select lands.
   task automatic t_prescale();
      wr(ADDR_COUNT, 8'h00);
      wr(ADDR_CTRL, ctl(3'h2, 2'h0, 2'h0, 1'b0));
      repeat (63) @(posedge core_clk_i);
      wr(ADDR_CTRL, 8'h00);
      rdc(ADDR_COUNT, 8'h08);
   endtask

   // The output is forced low first, so the set at bottom is really seen.
   task automatic t_fast();
      wr(ADDR_CTRL, ctl(3'h0, 2'h0, 2'h2, 1'b1));
      wr(ADDR_COMPARE, 8'h04);
      wr(ADDR_COUNT, 8'hfd);
      wr(ADDR_CTRL, ctl(3'h1, 2'h3, 2'h2, 1'b0));
      repeat (3) @(posedge core_clk_i);
      chk_bit(cout, 1'b1);
      repeat (5) @(posedge core_clk_i);
      chk_bit(cout, 1'b0);
      wr(ADDR_CTRL, 8'h00);
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (5) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      t_reset();
      t_count();
      t_overflow();
      t_compare();
      t_modes();
      t_output();
      t_buffer();
      t_crystal();
      t_prescale();
      t_fast();
      print_verdict();
   end
endmodule
